// File: verilog/autoneg_regs_cfg.svh
// register indices, field positions and reset values of the autoneg/gigabit register set
`ifndef AUTONEG_REGS_CFG_SVH
`define AUTONEG_REGS_CFG_SVH

`define IDX_PARTNER_BASE 8'h05
`define IDX_EXPANSION 8'h06
`define IDX_NP_TRANSMIT 8'h07
`define IDX_PARTNER_NP 8'h08
`define IDX_GIG_CONTROL 8'h09
`define IDX_GIG_STATUS 8'h0a

`define WORD_W 16
`define NP_MORE 15
`define NP_ACK 14
`define NP_MESSAGE 13
`define NP_COMPLY 12
`define NP_TOGGLE 11

`define EXP_PAR_FAULT 4
`define EXP_PARTNER_NP 3
`define EXP_LOCAL_NP 2
`define EXP_PAGE_RX 1
`define EXP_PARTNER_AN 0

`define GCTL_MODE_HI 15
`define GCTL_MODE_LO 13
`define GCTL_MS_MANUAL 12
`define GCTL_MS_VALUE 11
`define GCTL_PORT_TYPE 10
`define GCTL_GIG_FDX 9
`define GCTL_GIG_HDX 8

`define GSTS_MS_FAULT 15
`define GSTS_ROLE 14
`define GSTS_LOCAL_RX 13
`define GSTS_REMOTE_RX 12
`define GSTS_PARTNER_FDX 11
`define GSTS_PARTNER_HDX 10
`define GSTS_IDLE_HI 7
`define GSTS_IDLE_LO 0

`define BASE_RST 16'h0000
`define BASE_KEEP_MASK 16'hefff
`define PARTNER_NP_RST 16'h0000
`define NP_TX_RST 16'h2001
`define NP_TX_WR_MASK 16'hb7ff
`define GCTL_RST 16'h0700
`define ROLE_RST 1'b1
`define IDLE_MAX 8'hff
`define IDLE_ZERO 8'h00

`endif

// File: verilog/autoneg_regs_pkg.sv
// shared types of the autoneg/gigabit register set
package autoneg_regs_pkg;
  typedef logic [15:0] reg_word_t;
  typedef logic [7:0] idle_count_t;
  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0,
    TM_WAVEFORM = 3'h1,
    TM_JITTER_MASTER = 3'h2,
    TM_JITTER_SLAVE = 3'h3,
    TM_DISTORTION = 3'h4
  } tx_test_mode_t;
endpackage

// File: verilog/status_latch_if.sv
// carrier between the register front end and the latched status bank
`timescale 1ns/1ps
`default_nettype none
interface status_latch_if;
  logic par_fault_live;
  logic page_rx_evt;
  logic ms_fault_live;
  logic idle_err_evt;
  logic clr_expansion;
  logic clr_gig_status;
  logic snap_par_fault;
  logic snap_page_rx;
  logic snap_ms_fault;
  autoneg_regs_pkg::idle_count_t snap_idle_cnt;
  logic par_fault;
  logic page_rx;
  logic ms_fault;
  autoneg_regs_pkg::idle_count_t idle_cnt;
  modport front
  (
    output par_fault_live, page_rx_evt, ms_fault_live, idle_err_evt, clr_expansion, clr_gig_status,
    output snap_par_fault, snap_page_rx, snap_ms_fault, snap_idle_cnt,
    input par_fault, page_rx, ms_fault, idle_cnt
  );
  modport bank
  (
    input par_fault_live, page_rx_evt, ms_fault_live, idle_err_evt, clr_expansion, clr_gig_status,
    input snap_par_fault, snap_page_rx, snap_ms_fault, snap_idle_cnt,
    output par_fault, page_rx, ms_fault, idle_cnt
  );
endinterface
`default_nettype wire

// File: verilog/latched_status_bank.sv
// latched status bits and the idle error counter, cleared by reads
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_regs_cfg.svh"
module latched_status_bank
(
  input wire logic pclk,
  input wire logic presetn,
  status_latch_if.bank sl
);
  logic par_fault_reg;
  logic page_rx_reg;
  logic ms_fault_reg;
  autoneg_regs_pkg::idle_count_t idle_cnt_reg;
  logic par_fault_next;
  logic page_rx_next;
  logic ms_fault_next;
  autoneg_regs_pkg::idle_count_t idle_cnt_next;
  autoneg_regs_pkg::idle_count_t idle_base;

  // only the bits software actually saw are cleared; a new set always wins
  function automatic logic latch_next(input logic cur, input logic set, input logic clr, input logic seen);
    latch_next = set | (cur & ~(clr & seen));
  endfunction

  function automatic autoneg_regs_pkg::idle_count_t sat_inc(input autoneg_regs_pkg::idle_count_t v,
                                                            input logic inc);
    sat_inc = (inc && v != `IDLE_MAX) ? v + 8'h01 : v;
  endfunction

  assign par_fault_next = latch_next(par_fault_reg, sl.par_fault_live, sl.clr_expansion, sl.snap_par_fault);
  assign page_rx_next = latch_next(page_rx_reg, sl.page_rx_evt, sl.clr_expansion, sl.snap_page_rx);
  assign ms_fault_next = latch_next(ms_fault_reg, sl.ms_fault_live, sl.clr_gig_status, sl.snap_ms_fault);
  assign idle_base = sl.clr_gig_status ? idle_cnt_reg - sl.snap_idle_cnt : idle_cnt_reg;
  assign idle_cnt_next = sat_inc(idle_base, sl.idle_err_evt);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      par_fault_reg <= 1'b0;
      page_rx_reg <= 1'b0;
      ms_fault_reg <= 1'b0;
      idle_cnt_reg <= `IDLE_ZERO;
    end
    else
    begin
      par_fault_reg <= par_fault_next;
      page_rx_reg <= page_rx_next;
      ms_fault_reg <= ms_fault_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  assign sl.par_fault = par_fault_reg;
  assign sl.page_rx = page_rx_reg;
  assign sl.ms_fault = ms_fault_reg;
  assign sl.idle_cnt = idle_cnt_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_par_fault_latch: assert property (sl.par_fault_live |=> par_fault_reg)
    else $error("parallel fault not latched");
  a_ms_fault_hold: assert property (ms_fault_reg && !sl.clr_gig_status |=> ms_fault_reg)
    else $error("master/slave fault dropped before read");
  a_idle_saturate: assert property (idle_cnt_reg == `IDLE_MAX && !sl.clr_gig_status |=> idle_cnt_reg == `IDLE_MAX)
    else $error("idle error counter wrapped");
  a_read_clears: assert property (sl.clr_gig_status && !sl.ms_fault_live && sl.snap_ms_fault |=> !ms_fault_reg)
    else $error("read did not clear master/slave fault");
  c_idle_saturated: cover property (idle_cnt_reg == `IDLE_MAX && sl.idle_err_evt);
endmodule
`default_nettype wire

// File: verilog/autoneg_gigabit_status_regs.sv
// APB register set for partner ability, next pages and 1000BASE-T control/status
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_regs_cfg.svh"
module autoneg_gigabit_status_regs
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic partner_base_valid,
  input wire logic [15:0] partner_base_word,
  input wire logic partner_np_valid,
  input wire logic [15:0] partner_np_word,
  input wire logic partner_an_able,
  input wire logic par_fault_live,
  input wire logic partner_gig_fdx,
  input wire logic partner_gig_hdx,
  input wire logic ms_resolve_valid,
  input wire logic ms_resolve_master,
  input wire logic ms_fault_live,
  input wire logic local_rx_ok,
  input wire logic remote_rx_ok,
  input wire logic idle_err,
  input wire logic codeword_sent,
  input wire logic codeword_sent_toggle,
  output logic [15:0] np_tx_word,
  output logic [2:0] tx_test_mode,
  output logic test_mode_reserved,
  output logic ms_manual_en,
  output logic ms_force_master,
  output logic adv_multi_port,
  output logic adv_gig_fdx,
  output logic adv_gig_hdx
);
  status_latch_if sl();

  autoneg_regs_pkg::reg_word_t base_reg;
  autoneg_regs_pkg::reg_word_t partner_np_reg;
  autoneg_regs_pkg::reg_word_t np_tx_reg;
  autoneg_regs_pkg::reg_word_t gctl_reg;
  logic np_toggle_reg;
  logic role_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;

  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    addr_of = ADDR_W'({idx, 2'b00});
  endfunction

  // bus phases
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr_fire = access_phase & pwrite;
  wire rd_fire = access_phase & ~pwrite;

  // address decode
  wire hit_base = paddr == addr_of(`IDX_PARTNER_BASE);
  wire hit_exp = paddr == addr_of(`IDX_EXPANSION);
  wire hit_np_tx = paddr == addr_of(`IDX_NP_TRANSMIT);
  wire hit_partner_np = paddr == addr_of(`IDX_PARTNER_NP);
  wire hit_gctl = paddr == addr_of(`IDX_GIG_CONTROL);
  wire hit_gsts = paddr == addr_of(`IDX_GIG_STATUS);
  wire mapped = hit_base | hit_exp | hit_np_tx | hit_partner_np | hit_gctl | hit_gsts;

  // read words
  autoneg_regs_pkg::reg_word_t exp_word;
  autoneg_regs_pkg::reg_word_t np_tx_view;
  autoneg_regs_pkg::reg_word_t gsts_word;
  autoneg_regs_pkg::reg_word_t rd_word;

  always_comb
  begin
    exp_word = `BASE_RST;
    exp_word[`EXP_PAR_FAULT] = sl.par_fault;
    exp_word[`EXP_PARTNER_NP] = base_reg[`NP_MORE];
    exp_word[`EXP_LOCAL_NP] = 1'b1;
    exp_word[`EXP_PAGE_RX] = sl.page_rx;
    exp_word[`EXP_PARTNER_AN] = partner_an_able;
  end

  always_comb
  begin
    np_tx_view = np_tx_reg;
    np_tx_view[`NP_TOGGLE] = np_toggle_reg;
  end

  always_comb
  begin
    gsts_word = `BASE_RST;
    gsts_word[`GSTS_MS_FAULT] = sl.ms_fault;
    gsts_word[`GSTS_ROLE] = role_reg;
    gsts_word[`GSTS_LOCAL_RX] = local_rx_ok;
    gsts_word[`GSTS_REMOTE_RX] = remote_rx_ok;
    gsts_word[`GSTS_PARTNER_FDX] = partner_gig_fdx;
    gsts_word[`GSTS_PARTNER_HDX] = partner_gig_hdx;
    gsts_word[`GSTS_IDLE_HI:`GSTS_IDLE_LO] = sl.idle_cnt;
  end

  assign rd_word = hit_base ? base_reg :
                   hit_exp ? exp_word :
                   hit_np_tx ? np_tx_view :
                   hit_partner_np ? partner_np_reg :
                   hit_gctl ? gctl_reg :
                   hit_gsts ? gsts_word : `BASE_RST;

  // read data is sampled in the setup cycle, so the access cycle answers at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata_reg <= {16'h0000, rd_word};
      slverr_reg <= ~mapped;
    end
  end

  assign prdata = prdata_reg;
  assign pready = access_phase;
  assign pslverr = access_phase & slverr_reg;

  // latched status: clears act only on the bits returned by this read
  assign sl.par_fault_live = par_fault_live;
  assign sl.page_rx_evt = partner_base_valid | partner_np_valid;
  assign sl.ms_fault_live = ms_fault_live;
  assign sl.idle_err_evt = idle_err;
  assign sl.clr_expansion = rd_fire & hit_exp;
  assign sl.clr_gig_status = rd_fire & hit_gsts;
  assign sl.snap_par_fault = prdata_reg[`EXP_PAR_FAULT];
  assign sl.snap_page_rx = prdata_reg[`EXP_PAGE_RX];
  assign sl.snap_ms_fault = prdata_reg[`GSTS_MS_FAULT];
  assign sl.snap_idle_cnt = prdata_reg[`GSTS_IDLE_HI:`GSTS_IDLE_LO];

  latched_status_bank u_latched
  (
    .pclk(pclk),
    .presetn(presetn),
    .sl(sl)
  );

  // partner pages
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_reg <= `BASE_RST;
      partner_np_reg <= `PARTNER_NP_RST;
    end
    else
    begin
      if (partner_base_valid)
        base_reg <= partner_base_word & `BASE_KEEP_MASK;
      if (partner_np_valid)
        partner_np_reg <= partner_np_word;
    end
  end

  // next page transmit word, only the writable fields take bus data
  wire [15:0] np_tx_merge = (pwdata[15:0] & `NP_TX_WR_MASK) | (np_tx_reg & ~`NP_TX_WR_MASK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      np_tx_reg <= `NP_TX_RST;
    else if (wr_fire && hit_np_tx)
      np_tx_reg <= np_tx_merge;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      np_toggle_reg <= 1'b0;
    else if (codeword_sent)
      np_toggle_reg <= ~codeword_sent_toggle;
  end

  assign np_tx_word = np_tx_view;

  // gigabit control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gctl_reg <= `GCTL_RST;
    else if (wr_fire && hit_gctl)
      gctl_reg <= pwdata[15:0];
  end

  wire [2:0] mode_field = gctl_reg[`GCTL_MODE_HI:`GCTL_MODE_LO];
  assign tx_test_mode = mode_field;
  assign test_mode_reserved = mode_field > 3'(autoneg_regs_pkg::TM_DISTORTION);
  assign ms_manual_en = gctl_reg[`GCTL_MS_MANUAL];
  assign ms_force_master = gctl_reg[`GCTL_MS_MANUAL] & gctl_reg[`GCTL_MS_VALUE];
  assign adv_multi_port = gctl_reg[`GCTL_PORT_TYPE];
  assign adv_gig_fdx = gctl_reg[`GCTL_GIG_FDX];
  assign adv_gig_hdx = gctl_reg[`GCTL_GIG_HDX];

  // role is taken at every resolution pulse; timing swaps have no input here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      role_reg <= `ROLE_RST;
    else if (ms_resolve_valid)
      role_reg <= ms_resolve_master;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_base_capture: assert property (partner_base_valid |=> base_reg == $past(partner_base_word & `BASE_KEEP_MASK))
    else $error("partner base page not captured");
  a_base_ro: assert property (wr_fire && hit_base && !partner_base_valid |=> $stable(base_reg))
    else $error("write changed partner base page");
  a_exp_fixed: assert property (exp_word[15:5] == 11'h000 && exp_word[`EXP_LOCAL_NP])
    else $error("expansion fixed bits wrong");
  a_np_toggle: assert property (codeword_sent |=> np_tx_word[`NP_TOGGLE] == !$past(codeword_sent_toggle))
    else $error("toggle not inverse of sent codeword");
  a_np_write: assert property (wr_fire && hit_np_tx |=> np_tx_word[`NP_MORE] == $past(pwdata[`NP_MORE])
                               && np_tx_word[`NP_COMPLY] == $past(pwdata[`NP_COMPLY]) && !np_tx_word[`NP_ACK])
    else $error("next page transmit write wrong");
  a_np_receive: assert property (partner_np_valid |=> partner_np_reg == $past(partner_np_word))
    else $error("partner next page not captured");
  a_ms_force: assert property (!ms_manual_en |-> !ms_force_master)
    else $error("role forced while manual off");
  a_role_hold: assert property (!ms_resolve_valid |=> role_reg == $past(role_reg))
    else $error("role changed without resolution");
  a_gsts_reserved: assert property (gsts_word[9:8] == 2'b00 && gsts_word[`GSTS_LOCAL_RX] == local_rx_ok)
    else $error("status reserved or receiver bits wrong");
  a_test_mode_rsv: assert property (wr_fire && hit_gctl && pwdata[15:13] == 3'h5 |=> test_mode_reserved)
    else $error("reserved test mode not flagged");
  a_page_rx_read: assert property (partner_np_valid |=> sl.page_rx)
    else $error("page received not latched");

  c_exp_read: cover property (rd_fire && hit_exp && prdata_reg[`EXP_PAGE_RX]);
  c_np_write: cover property (wr_fire && hit_np_tx);
  c_role_slave: cover property (ms_resolve_valid && !ms_resolve_master);
  c_unmapped: cover property (access_phase && slverr_reg);
endmodule
`default_nettype wire

// File: testbench/link_partner_model.sv
// link partner model driving received pages and line status
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
(
  input wire logic pclk,
  output logic base_valid,
  output logic [15:0] base_word,
  output logic np_valid,
  output logic [15:0] np_word,
  output logic [6:0] levels,
  output logic ms_valid,
  output logic ms_master,
  output logic idle_err
);
  // levels: an_able, par_fault, ms_fault, local_rx, remote_rx, gig_fdx, gig_hdx
  initial
  begin
    base_valid = 1'b0;
    base_word = 16'h0000;
    np_valid = 1'b0;
    np_word = 16'h0000;
    levels = 7'h00;
    ms_valid = 1'b0;
    ms_master = 1'b0;
    idle_err = 1'b0;
  end
  // one page, base or next; released words show the inverse
  task send_page(input logic np, input logic [15:0] w);
    @(posedge pclk);
    base_valid <= !np;
    np_valid <= np;
    base_word <= w;
    np_word <= w;
    @(posedge pclk);
    base_valid <= 1'b0;
    np_valid <= 1'b0;
    base_word <= ~w;
    np_word <= ~w;
  endtask
  task set_levels(input logic [6:0] v);
    @(posedge pclk);
    levels <= v;
  endtask
  // role resolution pulse; afterwards the role line swaps, as a timing swap would
  task resolve(input logic m);
    @(posedge pclk);
    ms_valid <= 1'b1;
    ms_master <= m;
    @(posedge pclk);
    ms_valid <= 1'b0;
    ms_master <= ~m;
  endtask
  task idle_burst(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      idle_err <= 1'b1;
    end
    @(posedge pclk);
    idle_err <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/autoneg_gigabit_status_regs_tb_top.sv
// self-checking testbench for the autoneg/gigabit register set
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_regs_cfg.svh"
module autoneg_gigabit_status_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cw_sent, cw_toggle, err;
  logic bv, nv, msv, msm, ie, rsv, man, frc, amp, afd, ahd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bw, nw, np_tx_word;
  logic [6:0] lv;
  logic [2:0] tm;
  int error_cnt, samples_checked, cyc;
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  link_partner_model link_partner_model_inst (.pclk(pclk), .base_valid(bv), .base_word(bw), .np_valid(nv),
    .np_word(nw), .levels(lv), .ms_valid(msv), .ms_master(msm), .idle_err(ie));
  autoneg_gigabit_status_regs #(.ADDR_W(12)) autoneg_gigabit_status_regs_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .partner_base_valid(bv), .partner_base_word(bw),
    .partner_np_valid(nv), .partner_np_word(nw), .partner_an_able(lv[6]), .par_fault_live(lv[5]),
    .partner_gig_fdx(lv[1]), .partner_gig_hdx(lv[0]), .ms_resolve_valid(msv), .ms_resolve_master(msm),
    .ms_fault_live(lv[4]), .local_rx_ok(lv[3]), .remote_rx_ok(lv[2]), .idle_err(ie),
    .codeword_sent(cw_sent), .codeword_sent_toggle(cw_toggle), .np_tx_word(np_tx_word),
    .tx_test_mode(tm), .test_mode_reserved(rsv), .ms_manual_en(man), .ms_force_master(frc),
    .adv_multi_port(amp), .adv_gig_fdx(afd), .adv_gig_hdx(ahd));
  task end_sim;
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function logic [11:0] ra(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task apb(input logic wr, input logic [11:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, ra(i), 16'h0000);
    chk(rd, e);
  endtask
  task wr(input logic [7:0] i, input logic [15:0] d);
    apb(1'b1, ra(i), d);
  endtask
  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task t_defaults;
    rchk(`IDX_PARTNER_BASE, 32'h0);
    rchk(`IDX_EXPANSION, 32'h4);
    rchk(`IDX_NP_TRANSMIT, 32'h2001);
    rchk(`IDX_PARTNER_NP, 32'h0);
    rchk(`IDX_GIG_CONTROL, 32'h0700);
    rchk(`IDX_GIG_STATUS, 32'h4000);
    @(negedge pclk);
    chk({16'h0, np_tx_word}, 32'h2001);
    chk({23'h0, tm, rsv, man, frc, amp, afd, ahd}, 32'h7);
    $display("t_defaults done");
  endtask
  task t_pages;
    link_partner_model_inst.set_levels(7'h40);
    link_partner_model_inst.send_page(1'b0, 16'hffff);
    rchk(`IDX_PARTNER_BASE, 32'hefff);
    rchk(`IDX_EXPANSION, 32'hf);
    rchk(`IDX_EXPANSION, 32'hd);
    link_partner_model_inst.send_page(1'b0, 16'h0a5a);
    link_partner_model_inst.send_page(1'b1, 16'h5a5a);
    rchk(`IDX_PARTNER_NP, 32'h5a5a);
    rchk(`IDX_EXPANSION, 32'h7);
    wr(`IDX_PARTNER_BASE, 16'h1234);
    wr(`IDX_PARTNER_NP, 16'h0000);
    wr(`IDX_EXPANSION, 16'hffff);
    rchk(`IDX_PARTNER_BASE, 32'h0a5a);
    rchk(`IDX_PARTNER_NP, 32'h5a5a);
    link_partner_model_inst.set_levels(7'h00);
    rchk(`IDX_EXPANSION, 32'h4);
    $display("t_pages done");
  endtask
  task t_latch;
    link_partner_model_inst.set_levels(7'h20);
    link_partner_model_inst.set_levels(7'h00);
    rchk(`IDX_EXPANSION, 32'h14);
    rchk(`IDX_EXPANSION, 32'h4);
    link_partner_model_inst.set_levels(7'h10);
    rchk(`IDX_GIG_STATUS, 32'hc000);
    rchk(`IDX_GIG_STATUS, 32'hc000);
    link_partner_model_inst.set_levels(7'h00);
    rchk(`IDX_GIG_STATUS, 32'hc000);
    rchk(`IDX_GIG_STATUS, 32'h4000);
    $display("t_latch done");
  endtask
  task cw(input logic t);
    @(posedge pclk);
    cw_sent <= 1'b1;
    cw_toggle <= t;
    @(posedge pclk);
    cw_sent <= 1'b0;
    cw_toggle <= ~t;
  endtask
  task t_np_tx;
    wr(`IDX_NP_TRANSMIT, 16'hffff);
    rchk(`IDX_NP_TRANSMIT, 32'hb7ff);
    cw(1'b0);
    rchk(`IDX_NP_TRANSMIT, 32'hbfff);
    chk({16'h0, np_tx_word}, 32'hbfff);
    cw(1'b1);
    rchk(`IDX_NP_TRANSMIT, 32'hb7ff);
    $display("t_np_tx done");
  endtask
  task t_gctl;
    int m;
    // test modes are written while no media sense runs in this bench
    for (m = 0; m < 8; m++)
    begin
      wr(`IDX_GIG_CONTROL, {m[2:0], 13'h0});
      rchk(`IDX_GIG_CONTROL, {16'h0, m[2:0], 13'h0});
      chk({28'h0, tm, rsv}, {28'h0, m[2:0], m > 4});
    end
    chk({29'h0, amp, afd, ahd}, 32'h0);
    wr(`IDX_GIG_CONTROL, 16'h0800);
    @(negedge pclk);
    chk({30'h0, man, frc}, 32'h0);
    wr(`IDX_GIG_CONTROL, 16'h1000);
    @(negedge pclk);
    chk({30'h0, man, frc}, 32'h2);
    wr(`IDX_GIG_CONTROL, 16'h1fa5);
    rchk(`IDX_GIG_CONTROL, 32'h1fa5);
    chk({27'h0, man, frc, amp, afd, ahd}, 32'h1f);
    apb(1'b1, ra(8'h0b), 16'hffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, ra(8'h0b), 16'h0000);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("t_gctl done");
  endtask
  task t_status;
    link_partner_model_inst.resolve(1'b0);
    rchk(`IDX_GIG_STATUS, 32'h0);
    rchk(`IDX_GIG_STATUS, 32'h0);
    link_partner_model_inst.set_levels(7'h0f);
    rchk(`IDX_GIG_STATUS, 32'h3c00);
    wr(`IDX_GIG_STATUS, 16'hffff);
    rchk(`IDX_GIG_STATUS, 32'h3c00);
    link_partner_model_inst.set_levels(7'h00);
    link_partner_model_inst.idle_burst(3);
    rchk(`IDX_GIG_STATUS, 32'h3);
    rchk(`IDX_GIG_STATUS, 32'h0);
    link_partner_model_inst.idle_burst(300);
    rchk(`IDX_GIG_STATUS, 32'hff);
    link_partner_model_inst.resolve(1'b1);
    rchk(`IDX_GIG_STATUS, 32'h4000);
    $display("t_status done");
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cw_sent = 1'b0;
    cw_toggle = 1'b0;
    cyc = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults;
    t_pages;
    t_latch;
    t_np_tx;
    t_gctl;
    t_status;
    do_reset;
    t_defaults;
    end_sim;
  end
endmodule
`default_nettype wire
